/* hdl/swgc_age.sv */
// swgc_age: link-drop fast aging pass and normal aging interval
`timescale 1ns/1ns
module swgc_age #(
  parameter logic [35:0] FAST_CYC = 36'd200000,
  parameter logic [35:0] NORMAL_CYC = 36'd50000000000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic link_age_en,
  input wire logic [2:0] link_up,
  // aging actions
  output logic fast_active,
  output logic flush_all,
  output logic normal_tick
);
  logic [2:0] link_prev_reg;
  logic [35:0] cnt_reg, cnt_next;
  logic fast_reg, fast_next;
  logic link_drop, fast_end;

  assign link_drop = |(link_prev_reg & ~link_up);
  assign fast_end = fast_reg && (cnt_reg == FAST_CYC - 36'd1);
  assign fast_active = fast_reg;
  assign normal_tick = !fast_reg && (cnt_reg == NORMAL_CYC - 36'd1);

  always_comb begin
    fast_next = fast_reg;
    cnt_next = cnt_reg + 36'd1;
    if (link_age_en && link_drop) begin
      fast_next = 1'b1;
      cnt_next = 36'd0;
    end else if (fast_end || normal_tick) begin
      fast_next = 1'b0;
      cnt_next = 36'd0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_prev_reg <= 3'h0;
      cnt_reg <= 36'h0;
      fast_reg <= 1'b0;
      flush_all <= 1'b0;
    end else begin
      link_prev_reg <= link_up;
      cnt_reg <= cnt_next;
      fast_reg <= fast_next;
      flush_all <= link_age_en && link_drop;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_fast_start;
    @(posedge clk) disable iff (!rst_n)
      (link_age_en && link_drop) |=> (fast_active && flush_all && cnt_reg == 36'd0);
  endproperty
  a_fast_start: assert property (p_fast_start) else $error("no fast pass after link drop");

  property p_fast_return;
    @(posedge clk) disable iff (!rst_n)
      (fast_end && !(link_age_en && link_drop)) |=> (!fast_active && cnt_reg == 36'd0);
  endproperty
  a_fast_return: assert property (p_fast_return) else $error("fast pass did not return");

  property p_flush_cause;
    @(posedge clk) disable iff (!rst_n)
      flush_all |-> $past(link_age_en) && ($past(link_prev_reg) & ~$past(link_up)) != 3'h0;
  endproperty
  a_flush_cause: assert property (p_flush_cause) else $error("flush without unplug");

  c_fast_pass: cover property (@(posedge clk) disable iff (!rst_n) fast_end);
endmodule : swgc_age

/* hdl/swgc_boot.sv */
// swgc_boot: serial image check and default override at automatic start
`timescale 1ns/1ns
module swgc_boot #(
  parameter logic [7:0] FAMILY_ID = 8'h5a,
  parameter logic [3:0] CHIP_ID = 4'h3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic go,
  output logic done,
  // image port
  output logic ee_req,
  output logic [7:0] ee_addr,
  input wire logic ee_ack,
  input wire logic ee_nack,
  input wire logic [7:0] ee_data,
  // default override
  output logic ld_gc0,
  output logic ld_gc1,
  output logic [7:0] ld_data
);
  swgc_pkg::swgc_boot_t state_reg, state_next;
  logic id_ok;

  assign id_ok = (state_reg == swgc_pkg::BOOT_RD0) ? (ee_data == FAMILY_ID) : (ee_data[7:4] == CHIP_ID);
  assign ee_req = (state_reg != swgc_pkg::BOOT_IDLE) && (state_reg != swgc_pkg::BOOT_DONE);
  assign done = (state_reg == swgc_pkg::BOOT_DONE);
  assign ld_gc0 = (state_reg == swgc_pkg::BOOT_RD2) && ee_ack;
  assign ld_gc1 = (state_reg == swgc_pkg::BOOT_RD3) && ee_ack;
  assign ld_data = ee_data;

  always_comb begin
    case (state_reg)
      swgc_pkg::BOOT_RD0: ee_addr = swgc_pkg::EE_ADDR_ID0;
      swgc_pkg::BOOT_RD1: ee_addr = swgc_pkg::EE_ADDR_ID1;
      swgc_pkg::BOOT_RD2: ee_addr = swgc_pkg::EE_ADDR_GC0;
      swgc_pkg::BOOT_RD3: ee_addr = swgc_pkg::EE_ADDR_GC1;
      default: ee_addr = 8'h00;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      swgc_pkg::BOOT_IDLE: if (go) state_next = swgc_pkg::BOOT_RD0;
      swgc_pkg::BOOT_RD0, swgc_pkg::BOOT_RD1: begin
        if (ee_nack) state_next = swgc_pkg::BOOT_DONE;
        else if (ee_ack && !id_ok) state_next = swgc_pkg::BOOT_DONE;
        else if (ee_ack) state_next = (state_reg == swgc_pkg::BOOT_RD0) ? swgc_pkg::BOOT_RD1 : swgc_pkg::BOOT_RD2;
      end
      swgc_pkg::BOOT_RD2: if (ee_ack) state_next = swgc_pkg::BOOT_RD3;
      else if (ee_nack) state_next = swgc_pkg::BOOT_DONE;
      swgc_pkg::BOOT_RD3: if (ee_ack || ee_nack) state_next = swgc_pkg::BOOT_DONE;
      swgc_pkg::BOOT_DONE: state_next = swgc_pkg::BOOT_DONE;
      default: state_next = swgc_pkg::BOOT_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) state_reg <= swgc_pkg::BOOT_IDLE;
    else state_reg <= state_next;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_no_image_no_load;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == swgc_pkg::BOOT_RD0 && ee_nack) |=> (done && !ld_gc0 && !ld_gc1);
  endproperty
  a_no_image_no_load: assert property (p_no_image_no_load) else $error("load after absent image");

  property p_id_mismatch;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == swgc_pkg::BOOT_RD1 && ee_ack && ee_data[7:4] != CHIP_ID) |=> done [*4];
  endproperty
  a_id_mismatch: assert property (p_id_mismatch) else $error("image used despite id mismatch");
endmodule : swgc_boot

/* hdl/swgc_pkg.sv */
// swgc_pkg: offsets, reset values, timing constants and carrier types
package swgc_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] REG_ID0 = 8'h00;
  localparam logic [7:0] REG_ID1 = 8'h01;
  localparam logic [7:0] REG_GC0 = 8'h02;
  localparam logic [7:0] REG_GC1 = 8'h03;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int START_BIT = 0;
  localparam int GC0_BACKOFF = 7;
  localparam int GC0_FWD_FC = 3;
  localparam int GC0_LINK_AGE = 0;
  localparam int GC1_PASS_ALL = 7;
  localparam int GC1_TX_PAUSE = 5;
  localparam int GC1_RX_PAUSE = 4;
  localparam int GC1_LEN_CHK = 3;
  localparam logic [7:0] GC0_RO_MASK = 8'h70;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] GC0_RST = 8'h44;
  localparam logic [7:0] GC1_RST = 8'h30;
  localparam logic START_RST = 1'b1;
  // ----------------------------------------
  // image layout and frame limits
  // ----------------------------------------
  localparam logic [7:0] EE_ADDR_ID0 = 8'h00;
  localparam logic [7:0] EE_ADDR_ID1 = 8'h01;
  localparam logic [7:0] EE_ADDR_GC0 = 8'h02;
  localparam logic [7:0] EE_ADDR_GC1 = 8'h03;
  localparam logic [15:0] LEN_FIELD_MAX = 16'h05dc;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam longint unsigned CLK_PERIOD_NS = 4;
  localparam longint unsigned FAST_AGE_US = 800;
  localparam longint unsigned NORMAL_AGE_S = 200;
  localparam longint unsigned FAST_AGE_CYC = (FAST_AGE_US * 1000) / CLK_PERIOD_NS;
  localparam longint unsigned NORMAL_AGE_CYC = (NORMAL_AGE_S * 1000000000) / CLK_PERIOD_NS;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] len_type;
    logic [15:0] payload_len;
    logic is_flow_ctl;
    logic is_bad;
  } swgc_frame_t;

  typedef struct packed {
    logic backoff_alt;
    logic fwd_flow_ctl;
    logic pass_all;
    logic tx_pause_en;
    logic rx_pause_en;
    logic len_check_en;
  } swgc_ctl_t;

  typedef enum logic [2:0] {
    BOOT_IDLE = 3'b000,
    BOOT_RD0 = 3'b001,
    BOOT_RD1 = 3'b010,
    BOOT_RD2 = 3'b011,
    BOOT_RD3 = 3'b100,
    BOOT_DONE = 3'b101
  } swgc_boot_t;
endpackage : swgc_pkg

/* hdl/swgc_top.sv */
// swgc_top: global start gate, boot image check and global control registers
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns
module swgc_top #(
  parameter logic [7:0] FAMILY_ID = 8'h5a, // arbitrary value
  parameter logic [3:0] CHIP_ID = 4'h3, // arbitrary value
  parameter logic [2:0] REVISION_ID = 3'h1, // arbitrary value
  parameter logic [35:0] FAST_AGE_CYC = 36'(swgc_pkg::FAST_AGE_CYC),
  parameter logic [35:0] NORMAL_AGE_CYC = 36'(swgc_pkg::NORMAL_AGE_CYC)
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // mode straps
  input wire logic MODE_STRAP_HIGH,
  input wire logic MODE_STRAP_LOW,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // serial image port
  output logic EE_REQ,
  output logic [7:0] EE_ADDR,
  input wire logic EE_ACK,
  input wire logic EE_NACK,
  input wire logic [7:0] EE_DATA,
  // switch status
  output logic SWITCH_RUN,
  output swgc_pkg::swgc_ctl_t CTL,
  input wire logic SNIFFER_MODE,
  // frame admission
  input wire logic FRM_VALID,
  input wire swgc_pkg::swgc_frame_t FRM,
  output logic FRM_DONE,
  output logic FRM_DROP,
  // pause
  input wire logic PAUSE_RX,
  input wire logic PAUSE_TX_REQ,
  output logic PAUSE_HONOR,
  output logic PAUSE_SEND,
  // aging
  input wire logic [2:0] LINK_UP,
  output logic AGE_FAST,
  output logic AGE_FLUSH,
  output logic AGE_TICK
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] gc0_reg, gc0_next;
  logic [7:0] gc1_reg, gc1_next;
  logic start_reg, start_next;
  logic strap_cap_reg;
  logic auto_mode_reg;
  logic boot_go_reg;
  logic [7:0] rdata_next;
  logic wr_gc0, wr_gc1, wr_id1;
  logic boot_done, ld_gc0, ld_gc1;
  logic [7:0] ld_data;
  logic pass_all_eff, len_bad, frm_drop_next;

  function automatic logic [7:0] gc0_merge(input logic [7:0] cur, input logic [7:0] wd);
    gc0_merge = (cur & swgc_pkg::GC0_RO_MASK) | (wd & ~swgc_pkg::GC0_RO_MASK);
  endfunction : gc0_merge

  assign wr_gc0 = REG_WR && (REG_ADDR == swgc_pkg::REG_GC0);
  assign wr_gc1 = REG_WR && (REG_ADDR == swgc_pkg::REG_GC1);
  assign wr_id1 = REG_WR && (REG_ADDR == swgc_pkg::REG_ID1);

  // image load takes priority over a software write in the same cycle
  assign gc0_next = ld_gc0 ? gc0_merge(gc0_reg, ld_data) : wr_gc0 ? gc0_merge(gc0_reg, REG_WDATA) : gc0_reg;
  assign gc1_next = ld_gc1 ? ld_data : wr_gc1 ? REG_WDATA : gc1_reg;
  assign start_next = wr_id1 ? REG_WDATA[swgc_pkg::START_BIT] : start_reg;

  always_comb begin
    case (REG_ADDR)
      swgc_pkg::REG_ID0: rdata_next = FAMILY_ID;
      swgc_pkg::REG_ID1: rdata_next = {CHIP_ID, REVISION_ID, start_reg};
      swgc_pkg::REG_GC0: rdata_next = gc0_reg;
      swgc_pkg::REG_GC1: rdata_next = gc1_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      gc0_reg <= swgc_pkg::GC0_RST;
      gc1_reg <= swgc_pkg::GC1_RST;
      start_reg <= swgc_pkg::START_RST;
      REG_RDATA <= 8'h00;
    end else begin
      gc0_reg <= gc0_next;
      gc1_reg <= gc1_next;
      start_reg <= start_next;
      REG_RDATA <= REG_RD ? rdata_next : 8'h00;
    end
  end

  // ----------------------------------------
  // start gate
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      strap_cap_reg <= 1'b0;
      auto_mode_reg <= 1'b0;
      boot_go_reg <= 1'b0;
    end else begin
      strap_cap_reg <= 1'b1;
      if (!strap_cap_reg) auto_mode_reg <= !MODE_STRAP_HIGH && !MODE_STRAP_LOW;
      boot_go_reg <= !strap_cap_reg && !MODE_STRAP_HIGH && !MODE_STRAP_LOW;
    end
  end

  assign SWITCH_RUN = strap_cap_reg && (auto_mode_reg ? boot_done : start_reg);

  swgc_boot #(
    .FAMILY_ID(FAMILY_ID),
    .CHIP_ID(CHIP_ID)
  ) u_boot (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .go(boot_go_reg),
    .done(boot_done),
    .ee_req(EE_REQ),
    .ee_addr(EE_ADDR),
    .ee_ack(EE_ACK),
    .ee_nack(EE_NACK),
    .ee_data(EE_DATA),
    .ld_gc0(ld_gc0),
    .ld_gc1(ld_gc1),
    .ld_data(ld_data)
  );

  // ----------------------------------------
  // control outputs
  // ----------------------------------------
  assign pass_all_eff = gc1_reg[swgc_pkg::GC1_PASS_ALL] && SNIFFER_MODE;
  assign CTL.backoff_alt = gc0_reg[swgc_pkg::GC0_BACKOFF];
  assign CTL.fwd_flow_ctl = gc0_reg[swgc_pkg::GC0_FWD_FC];
  assign CTL.pass_all = pass_all_eff;
  assign CTL.tx_pause_en = gc1_reg[swgc_pkg::GC1_TX_PAUSE];
  assign CTL.rx_pause_en = gc1_reg[swgc_pkg::GC1_RX_PAUSE];
  assign CTL.len_check_en = gc1_reg[swgc_pkg::GC1_LEN_CHK];

  // ----------------------------------------
  // frame admission and pause
  // ----------------------------------------
  assign len_bad = CTL.len_check_en && (FRM.len_type < swgc_pkg::LEN_FIELD_MAX)
                   && (FRM.len_type != FRM.payload_len);
  assign frm_drop_next = (FRM.is_flow_ctl && !CTL.fwd_flow_ctl)
                         || (!pass_all_eff && (len_bad || FRM.is_bad));

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      FRM_DONE <= 1'b0;
      FRM_DROP <= 1'b0;
      PAUSE_HONOR <= 1'b0;
      PAUSE_SEND <= 1'b0;
    end else begin
      FRM_DONE <= FRM_VALID;
      FRM_DROP <= FRM_VALID && frm_drop_next;
      PAUSE_HONOR <= PAUSE_RX && CTL.rx_pause_en;
      PAUSE_SEND <= PAUSE_TX_REQ && CTL.tx_pause_en && SWITCH_RUN;
    end
  end

  swgc_age #(
    .FAST_CYC(FAST_AGE_CYC),
    .NORMAL_CYC(NORMAL_AGE_CYC)
  ) u_age (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .link_age_en(gc0_reg[swgc_pkg::GC0_LINK_AGE]),
    .link_up(LINK_UP),
    .fast_active(AGE_FAST),
    .flush_all(AGE_FLUSH),
    .normal_tick(AGE_TICK)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_run_gate;
    @(posedge REF_CLK) disable iff (!RST_N)
      (strap_cap_reg && !auto_mode_reg && start_reg) |-> SWITCH_RUN;
  endproperty
  a_run_gate: assert property (p_run_gate) else $error("switch idle with start set");

  property p_halt;
    @(posedge REF_CLK) disable iff (!RST_N)
      (!auto_mode_reg && wr_id1 && !REG_WDATA[0]) |=> !SWITCH_RUN;
  endproperty
  a_halt: assert property (p_halt) else $error("switch runs with start cleared");

  property p_auto_start;
    @(posedge REF_CLK) disable iff (!RST_N)
      (auto_mode_reg && strap_cap_reg) |-> (SWITCH_RUN == boot_done);
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("automatic start wrong");

  property p_backoff;
    @(posedge REF_CLK) disable iff (!RST_N)
      (wr_gc0 && !ld_gc0) |=> (CTL.backoff_alt == $past(REG_WDATA[7]) && gc0_reg[6:4] == 3'b100);
  endproperty
  a_backoff: assert property (p_backoff) else $error("back-off select or reserved field wrong");

  property p_fc_drop;
    @(posedge REF_CLK) disable iff (!RST_N)
      (FRM_VALID && FRM.is_flow_ctl && !CTL.fwd_flow_ctl) |=> (FRM_DONE && FRM_DROP);
  endproperty
  a_fc_drop: assert property (p_fc_drop) else $error("flow-control frame passed");

  property p_pass_all;
    @(posedge REF_CLK) disable iff (!RST_N)
      (FRM_VALID && pass_all_eff && !FRM.is_flow_ctl) |=> !FRM_DROP;
  endproperty
  a_pass_all: assert property (p_pass_all) else $error("frame dropped in pass-all");

  property p_no_pause_tx;
    @(posedge REF_CLK) disable iff (!RST_N)
      !CTL.tx_pause_en |=> !PAUSE_SEND;
  endproperty
  a_no_pause_tx: assert property (p_no_pause_tx) else $error("pause sent while disabled");

  property p_pause_rx;
    @(posedge REF_CLK) disable iff (!RST_N)
      PAUSE_RX |=> (PAUSE_HONOR == $past(CTL.rx_pause_en));
  endproperty
  a_pause_rx: assert property (p_pause_rx) else $error("pause reaction wrong");

  property p_len_drop;
    @(posedge REF_CLK) disable iff (!RST_N)
      (FRM_VALID && len_bad && !pass_all_eff) |=> FRM_DROP;
  endproperty
  a_len_drop: assert property (p_len_drop) else $error("length mismatch not dropped");

  property p_fc_pass;
    @(posedge REF_CLK) disable iff (!RST_N)
      (FRM_VALID && FRM.is_flow_ctl && CTL.fwd_flow_ctl && !FRM.is_bad && !len_bad) |=> !FRM_DROP;
  endproperty
  a_fc_pass: assert property (p_fc_pass) else $error("flow-control frame dropped while forwarding");

  property p_len_off;
    @(posedge REF_CLK) disable iff (!RST_N)
      (FRM_VALID && !CTL.len_check_en && !FRM.is_bad && !FRM.is_flow_ctl) |=> !FRM_DROP;
  endproperty
  a_len_off: assert property (p_len_off) else $error("frame dropped with length check off");

  property p_pause_tx_on;
    @(posedge REF_CLK) disable iff (!RST_N)
      (PAUSE_TX_REQ && CTL.tx_pause_en && SWITCH_RUN) |=> PAUSE_SEND;
  endproperty
  a_pause_tx_on: assert property (p_pause_tx_on) else $error("pause not sent while enabled");

  property p_halt_no_pause;
    @(posedge REF_CLK) disable iff (!RST_N)
      !SWITCH_RUN |=> !PAUSE_SEND;
  endproperty
  a_halt_no_pause: assert property (p_halt_no_pause) else $error("pause sent while halted");

  property p_ro_field;
    @(posedge REF_CLK) disable iff (!RST_N)
      gc0_reg[6:4] == 3'b100;
  endproperty
  a_ro_field: assert property (p_ro_field) else $error("read-only field of control zero changed");

  property p_image_gc0;
    @(posedge REF_CLK) disable iff (!RST_N)
      ld_gc0 |=> (gc0_reg[7] == $past(ld_data[7]) && gc0_reg[3:0] == $past(ld_data[3:0]));
  endproperty
  a_image_gc0: assert property (p_image_gc0) else $error("image byte not loaded into control zero");

  property p_image_gc1;
    @(posedge REF_CLK) disable iff (!RST_N)
      ld_gc1 |=> (gc1_reg == $past(ld_data));
  endproperty
  a_image_gc1: assert property (p_image_gc1) else $error("image byte not loaded into control one");

  property p_reset_defaults;
    @(posedge REF_CLK) !strap_cap_reg && RST_N |-> (gc0_reg == 8'h44 && gc1_reg == 8'h30 && start_reg);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("defaults missing after reset");

  c_auto_run: cover property (@(posedge REF_CLK) disable iff (!RST_N) auto_mode_reg && SWITCH_RUN);
  c_halted: cover property (@(posedge REF_CLK) disable iff (!RST_N) !auto_mode_reg && !SWITCH_RUN);
  c_len_drop: cover property (@(posedge REF_CLK) disable iff (!RST_N) FRM_DROP);
endmodule : swgc_top

/* tb/swgc_ee_model.sv */
// swgc_ee_model: serial image model answering byte requests
`timescale 1ns/1ns
module swgc_ee_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // image port
  input wire logic req,
  input wire logic [7:0] addr,
  output logic ack,
  output logic nack,
  output logic [7:0] data
);
  logic [7:0] img [4];
  logic absent;
  int delay;
  int cnt;
  initial begin
    absent = 1'b0;
    delay = 0;
  end
  // one answer per byte, data toggles when not valid
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      nack <= 1'b0;
      data <= 8'h00;
      cnt <= 0;
    end else if (ack || nack) begin
      ack <= 1'b0;
      nack <= 1'b0;
      data <= ~data;
      cnt <= 0;
    end else if (req && cnt >= delay) begin
      ack <= !absent;
      nack <= absent;
      data <= absent ? ~data : img[addr[1:0]];
    end else begin
      data <= ~data;
      cnt <= req ? cnt + 1 : 0;
    end
  end
endmodule : swgc_ee_model

/* tb/test_swgc_top.sv */
// test_swgc_top: self-checking bench for start gate, image check and control bits
`timescale 1ns/1ns
module test_swgc_top;
  localparam logic [7:0] FAM = 8'h5a; // arbitrary value
  localparam logic [3:0] CHIP = 4'h3; // arbitrary value
  localparam logic [2:0] REV = 3'h1; // arbitrary value
  localparam int FAST = 20;
  localparam int NORM = 50;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic s_hi = 1'b0;
  logic s_lo = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata, ee_addr, ee_data;
  logic ee_req, ee_ack, ee_nack, run, done, drop, honor, psend, afast, aflush, atick;
  swgc_pkg::swgc_ctl_t ctl;
  logic sniff = 1'b0;
  logic fv = 1'b0;
  swgc_pkg::swgc_frame_t frm = '0;
  logic prx = 1'b0;
  logic ptx = 1'b0;
  logic [2:0] link = 3'b111;
  logic [7:0] m_gc0, m_gc1;
  logic m_start;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  swgc_top #(.FAMILY_ID(FAM), .CHIP_ID(CHIP), .REVISION_ID(REV), .FAST_AGE_CYC(36'd20),
    .NORMAL_AGE_CYC(36'd50)) i_dut (
    .REF_CLK(clk), .RST_N(rst_n), .MODE_STRAP_HIGH(s_hi), .MODE_STRAP_LOW(s_lo),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .EE_REQ(ee_req), .EE_ADDR(ee_addr), .EE_ACK(ee_ack), .EE_NACK(ee_nack), .EE_DATA(ee_data),
    .SWITCH_RUN(run), .CTL(ctl), .SNIFFER_MODE(sniff), .FRM_VALID(fv), .FRM(frm),
    .FRM_DONE(done), .FRM_DROP(drop), .PAUSE_RX(prx), .PAUSE_TX_REQ(ptx),
    .PAUSE_HONOR(honor), .PAUSE_SEND(psend), .LINK_UP(link), .AGE_FAST(afast),
    .AGE_FLUSH(aflush), .AGE_TICK(atick));
  swgc_ee_model i_ee (.clk(clk), .rst_n(rst_n), .req(ee_req), .addr(ee_addr), .ack(ee_ack),
    .nack(ee_nack), .data(ee_data));
  // ----
  // tasks
  // ----
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic reg_wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (a == 8'h01) m_start = d[0];
    if (a == 8'h02) m_gc0 = (d & 8'h8f) | 8'h40;
    if (a == 8'h03) m_gc1 = d;
  endtask : reg_wr
  function automatic logic [7:0] exp_reg(logic [7:0] a);
    case (a)
      8'h00: return FAM;
      8'h01: return {CHIP, REV, m_start};
      8'h02: return m_gc0;
      8'h03: return m_gc1;
      default: return 8'h00;
    endcase
  endfunction : exp_reg
  task automatic chk_regs();
    logic [7:0] al [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10};
    foreach (al[i]) begin
      @(posedge clk);
      addr <= al[i];
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("rdata", {8'h00, exp_reg(al[i])}, {8'h00, rdata});
    end
    chk("ctl", {10'h000, m_gc0[7], m_gc0[3], m_gc1[7] & sniff, m_gc1[5:3]}, {10'h000, ctl});
  endtask : chk_regs
  task automatic do_reset(logic hi, logic lo);
    @(posedge clk);
    s_hi <= hi;
    s_lo <= lo;
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    m_gc0 = 8'h44;
    m_gc1 = 8'h30;
    m_start = 1'b1;
  endtask : do_reset
  task automatic pause_test(logic [2:0] k);
    reg_wr(8'h03, {2'b00, k[0], k[1], 4'h0});
    reg_wr(8'h01, {7'h00, k[2]});
    @(posedge clk);
    prx <= 1'b1;
    ptx <= 1'b1;
    @(posedge clk);
    prx <= 1'b0;
    ptx <= 1'b0;
    #1 chk("honor", 16'(k[1]), 16'(honor));
    chk("send", 16'(k[0] & k[2]), 16'(psend));
    chk("run", 16'(k[2]), 16'(run));
  endtask : pause_test
  task automatic frame_test();
    logic [15:0] len, pay;
    logic fc, bad, pa, exp;
    len = 16'(1490 + $urandom_range(20));
    pay = $urandom_range(1) ? len : 16'(1490 + $urandom_range(20));
    fc = 1'($urandom_range(1));
    bad = $urandom_range(3) == 0;
    pa = m_gc1[7] & sniff;
    exp = (fc & !m_gc0[3]) | (!pa & (bad | (m_gc1[3] & len < 1500 & len != pay)));
    @(posedge clk);
    fv <= 1'b1;
    frm <= '{len, pay, fc, bad};
    @(posedge clk);
    fv <= 1'b0;
    #1 chk("done", 16'h0001, 16'(done));
    chk("drop", 16'(exp), 16'(drop));
  endtask : frame_test
  task automatic age_test(logic en);
    int n;
    reg_wr(8'h02, {m_gc0[7:1], en});
    @(posedge clk);
    link <= 3'b101;
    @(posedge clk);
    #1 chk("flush", 16'(en), 16'(aflush));
    n = 0;
    while (afast === 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
      #1;
    end
    chk("fast_len", en ? 16'(FAST) : 16'h0000, 16'(n));
    n = 0;
    while (atick !== 1'b1 && n < 3 * NORM) begin
      @(posedge clk);
      #1 n++;
    end
    chk("tick_gap", 16'h0001, 16'(n <= NORM + 1));
    @(posedge clk);
    link <= 3'b111;
  endtask : age_test
  task automatic boot_test(logic absent, int dly, logic [7:0] b0, logic [3:0] b1, logic load);
    logic [7:0] g0, g1;
    int n;
    g0 = (8'($urandom) & 8'hf9) | 8'h04;
    g1 = 8'($urandom) & 8'hb8;
    i_ee.absent = absent;
    i_ee.delay = dly;
    i_ee.img = '{b0, {b1, 4'h0}, g0, g1};
    do_reset(1'b0, 1'b0);
    #1 chk("run_early", 16'h0000, 16'(run));
    n = 0;
    while (run !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
    chk("run_boot", 16'h0001, 16'(run));
    if (load) begin
      m_gc0 = (g0 & 8'h8f) | 8'h40;
      m_gc1 = g1;
    end
    chk_regs();
  endtask : boot_test
  // ----
  // sequence
  // ----
  initial begin
    void'($urandom(13573));
    do_reset(1'b0, 1'b1);
    @(posedge clk);
    #1 chk("run", 16'h0001, 16'(run));
    chk_regs();
    $display("test reset_values done");
    reg_wr(8'h00, 8'h33);
    reg_wr(8'h02, 8'h04);
    chk_regs();
    for (int i = 0; i < 8; i++) begin
      reg_wr(8'h02, (8'($urandom) & 8'h89) | 8'h44);
      reg_wr(8'h03, 8'($urandom) & 8'hb8);
      sniff <= 1'($urandom);
      chk_regs();
      repeat (5) frame_test();
    end
    $display("test control_frames done");
    for (int k = 0; k < 8; k++) pause_test(3'(k));
    reg_wr(8'h01, 8'h01);
    $display("test start_pause done");
    age_test(1'b0);
    age_test(1'b1);
    $display("test aging done");
    boot_test(1'b1, 0, FAM, CHIP, 1'b0);
    boot_test(1'b0, 3, FAM, CHIP, 1'b1);
    boot_test(1'b0, 0, FAM ^ 8'h01, CHIP, 1'b0);
    boot_test(1'b0, 1, FAM, CHIP ^ 4'h1, 1'b0);
    $display("test boot done");
    give_verdict();
  end
endmodule : test_swgc_top
